// [hw/drt_pkg.sv]
// constants and carrier types for the dscp priority remap table
// assumes one clock domain and a 32-bit axi4-lite register bus
package drt_pkg;

  localparam int          ADDR_W        = 12;
  localparam int          DATA_W        = 32;
  localparam int          IDX_W         = 10;
  localparam int          IDX_LSB       = 2;
  localparam int          DSCP_W        = 6;
  localparam int          PRIO_W        = 3;
  localparam int          PAIR_W        = 5;
  localparam int          SLOT_W        = 4;
  localparam int          MAP_REGS      = 12;

  // register indices; byte address is four times the index
  localparam logic [9:0]  IDX_REMAP_EN  = 10'h33E;
  localparam logic [9:0]  IDX_STATUS    = 10'h33F;
  localparam logic [9:0]  IDX_MAP_FIRST = 10'h343;
  localparam logic [9:0]  IDX_MAP_LAST  = 10'h34E;
  localparam logic [9:0]  IDX_MAP_06_07 = 10'h343;
  localparam logic [9:0]  IDX_MAP_08_09 = 10'h344;
  localparam logic [9:0]  IDX_MAP_0A_0B = 10'h345;
  localparam logic [9:0]  IDX_MAP_0C_0D = 10'h346;
  localparam logic [9:0]  IDX_MAP_0E_0F = 10'h347;
  localparam logic [9:0]  IDX_MAP_10_11 = 10'h348;
  localparam logic [9:0]  IDX_MAP_12_13 = 10'h349;
  localparam logic [9:0]  IDX_MAP_14_15 = 10'h34A;
  localparam logic [9:0]  IDX_MAP_16_17 = 10'h34B;
  localparam logic [9:0]  IDX_MAP_18_19 = 10'h34C;
  localparam logic [9:0]  IDX_MAP_1A_1B = 10'h34D;
  localparam logic [9:0]  IDX_MAP_1C_1D = 10'h34E;

  // dscp[5:1] of the first and last covered code point pair
  localparam logic [4:0]  PAIR_FIRST    = 5'h03;
  localparam logic [4:0]  PAIR_LAST     = 5'h0E;
  localparam logic [4:0]  PAIR_06_07    = 5'h03;
  localparam logic [4:0]  PAIR_08_09    = 5'h04;
  localparam logic [4:0]  PAIR_0A_0B    = 5'h05;
  localparam logic [4:0]  PAIR_0C_0D    = 5'h06;
  localparam logic [4:0]  PAIR_0E_0F    = 5'h07;
  localparam logic [4:0]  PAIR_10_11    = 5'h08;
  localparam logic [4:0]  PAIR_12_13    = 5'h09;
  localparam logic [4:0]  PAIR_14_15    = 5'h0A;
  localparam logic [4:0]  PAIR_16_17    = 5'h0B;
  localparam logic [4:0]  PAIR_18_19    = 5'h0C;
  localparam logic [4:0]  PAIR_1A_1B    = 5'h0D;
  localparam logic [4:0]  PAIR_1C_1D    = 5'h0E;

  // storage slot of each map register
  localparam logic [3:0]  SLOT_06_07    = 4'h0;
  localparam logic [3:0]  SLOT_08_09    = 4'h1;
  localparam logic [3:0]  SLOT_0A_0B    = 4'h2;
  localparam logic [3:0]  SLOT_0C_0D    = 4'h3;
  localparam logic [3:0]  SLOT_0E_0F    = 4'h4;
  localparam logic [3:0]  SLOT_10_11    = 4'h5;
  localparam logic [3:0]  SLOT_12_13    = 4'h6;
  localparam logic [3:0]  SLOT_14_15    = 4'h7;
  localparam logic [3:0]  SLOT_16_17    = 4'h8;
  localparam logic [3:0]  SLOT_18_19    = 4'h9;
  localparam logic [3:0]  SLOT_1A_1B    = 4'hA;
  localparam logic [3:0]  SLOT_1C_1D    = 4'hB;

  // field positions inside the map, enable and status registers, and of the dscp class bits
  localparam int          LO_LSB        = 0;
  localparam int          HI_LSB        = 4;
  localparam int          REMAP_EN_BIT  = 0;
  localparam int          ST_PRIO_LSB   = 0;
  localparam int          ST_REMAP_BIT  = 3;
  localparam int          ST_DSCP_LSB   = 8;
  localparam int          CLASS_LSB     = 3;

  localparam logic [2:0]  MAP_RESET     = 3'h0;
  localparam logic        REMAP_EN_RST  = 1'b0;

  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_DECERR   = 2'h3;

  typedef struct packed {
    logic             valid;
    logic [DSCP_W-1:0] dscp;
  } drt_dscp_req_s;

  typedef struct packed {
    logic             valid;
    logic             remapped;
    logic [PRIO_W-1:0] prio;
  } drt_prio_rsp_s;

  typedef struct packed {
    logic              hit;
    logic [SLOT_W-1:0] slot;
  } drt_slot_s;

endpackage

// [hw/drt_remap_table.sv]
// dscp to internal priority remap table with axi4-lite register access
// assumes the classifier request comes from logic on clk_sys, so it is not synchronised
// What this block does
// - dscp 0x06 uses bits 2:0, 0x07 bits 6:4 of first map register; reset zero.
// - dscp 0x08 and 0x09 use low and high fields at index 0x344.
// - dscp 0x0A and 0x0B use low and high fields at index 0x345.
// - dscp 0x0C and 0x0D use low and high fields of fourth register.
// - dscp 0x0E and 0x0F use low and high fields at index 0x347.
// - dscp 0x10 and 0x11 use low and high fields at index 0x348.
// - dscp 0x12 and 0x13 use low and high fields at index 0x349.
// - dscp 0x14 and 0x15 use low and high fields at index 0x34A.
// - dscp 0x16 and 0x17 use low and high fields at index 0x34B.
// - dscp 0x18 and 0x19 use low and high fields at index 0x34C.
// - dscp 0x1A and 0x1B use low and high fields at index 0x34D.
// - dscp 0x1C and 0x1D use low and high fields of twelfth register.
// - with remap enabled, priority of dscp 0x06 to 0x1D comes from the map registers; other code points use dscp bits 5:3.
// - with remap disabled, priority is dscp bits 5:3 directly.
`timescale 1ns/10ps
module drt_remap_table (
  input  wire logic                  clk_sys,
  input  wire logic                  reset,
  input  wire logic [11:0]           s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [11:0]           s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire drt_pkg::drt_dscp_req_s cls_req,
  output drt_pkg::drt_prio_rsp_s     cls_rsp
);
  import drt_pkg::*;

  logic [PRIO_W-1:0]  map_lo_q [MAP_REGS];
  logic [PRIO_W-1:0]  map_hi_q [MAP_REGS];
  logic               remap_en_q;
  logic               aw_held_q;
  logic [IDX_W-1:0]   aw_idx_q;
  logic               w_held_q;
  logic [DATA_W-1:0]  wdata_q;
  logic               wlane0_q;
  logic               bvalid_q;
  logic [1:0]         bresp_q;
  logic               rvalid_q;
  logic [1:0]         rresp_q;
  logic [DATA_W-1:0]  rdata_q;
  drt_prio_rsp_s      rsp_q;
  logic [DSCP_W-1:0]  last_dscp_q;
  logic               do_write;
  logic [IDX_W-1:0]   ar_idx;
  logic [PAIR_W-1:0]  req_pair;
  logic               req_covered;
  logic [SLOT_W-1:0]  req_slot;
  logic [PRIO_W-1:0]  table_prio;
  drt_prio_rsp_s      rsp_d;
  drt_slot_s          aw_sel;
  drt_slot_s          ar_sel;
  drt_slot_s          req_sel;

  function automatic logic is_map(input logic [IDX_W-1:0] idx);
    return (idx >= IDX_MAP_FIRST) && (idx <= IDX_MAP_LAST);
  endfunction

  function automatic logic is_mapped(input logic [IDX_W-1:0] idx);
    return is_map(idx) || (idx == IDX_REMAP_EN) || (idx == IDX_STATUS);
  endfunction

  // one decode per register keeps each bus index tied to its code point pair
  function automatic drt_slot_s reg_slot(input logic [IDX_W-1:0] idx);
    drt_slot_s sel;
    sel = '0;
    unique case (idx)
      IDX_MAP_06_07: begin
        sel.hit  = 1'b1;
        sel.slot = SLOT_06_07;
      end

      IDX_MAP_08_09: begin
        sel.hit  = 1'b1;
        sel.slot = SLOT_08_09;
      end

      IDX_MAP_0A_0B: begin
        sel.hit  = 1'b1;
        sel.slot = SLOT_0A_0B;
      end

      IDX_MAP_0C_0D: begin
        sel.hit  = 1'b1;
        sel.slot = SLOT_0C_0D;
      end

      IDX_MAP_0E_0F: begin
        sel.hit  = 1'b1;
        sel.slot = SLOT_0E_0F;
      end

      IDX_MAP_10_11: begin
        sel.hit  = 1'b1;
        sel.slot = SLOT_10_11;
      end

      IDX_MAP_12_13: begin
        sel.hit  = 1'b1;
        sel.slot = SLOT_12_13;
      end

      IDX_MAP_14_15: begin
        sel.hit  = 1'b1;
        sel.slot = SLOT_14_15;
      end

      IDX_MAP_16_17: begin
        sel.hit  = 1'b1;
        sel.slot = SLOT_16_17;
      end

      IDX_MAP_18_19: begin
        sel.hit  = 1'b1;
        sel.slot = SLOT_18_19;
      end

      IDX_MAP_1A_1B: begin
        sel.hit  = 1'b1;
        sel.slot = SLOT_1A_1B;
      end

      IDX_MAP_1C_1D: begin
        sel.hit  = 1'b1;
        sel.slot = SLOT_1C_1D;
      end
      default: begin
        sel = '0;
      end
    endcase
    return sel;
  endfunction

  function automatic drt_slot_s pair_slot(input logic [PAIR_W-1:0] pair);
    drt_slot_s sel;
    sel = '0;
    unique case (pair)
      PAIR_06_07: begin
        sel.hit  = 1'b1;
        sel.slot = SLOT_06_07;
      end

      PAIR_08_09: begin
        sel.hit  = 1'b1;
        sel.slot = SLOT_08_09;
      end

      PAIR_0A_0B: begin
        sel.hit  = 1'b1;
        sel.slot = SLOT_0A_0B;
      end

      PAIR_0C_0D: begin
        sel.hit  = 1'b1;
        sel.slot = SLOT_0C_0D;
      end

      PAIR_0E_0F: begin
        sel.hit  = 1'b1;
        sel.slot = SLOT_0E_0F;
      end

      PAIR_10_11: begin
        sel.hit  = 1'b1;
        sel.slot = SLOT_10_11;
      end

      PAIR_12_13: begin
        sel.hit  = 1'b1;
        sel.slot = SLOT_12_13;
      end

      PAIR_14_15: begin
        sel.hit  = 1'b1;
        sel.slot = SLOT_14_15;
      end

      PAIR_16_17: begin
        sel.hit  = 1'b1;
        sel.slot = SLOT_16_17;
      end

      PAIR_18_19: begin
        sel.hit  = 1'b1;
        sel.slot = SLOT_18_19;
      end

      PAIR_1A_1B: begin
        sel.hit  = 1'b1;
        sel.slot = SLOT_1A_1B;
      end

      PAIR_1C_1D: begin
        sel.hit  = 1'b1;
        sel.slot = SLOT_1C_1D;
      end
      default: begin
        sel = '0;
      end
    endcase
    return sel;
  endfunction

  // write address and data are taken in either order; no new beat until bvalid is retired
  assign s_axi_awready = !aw_held_q && !bvalid_q;
  assign s_axi_wready  = !w_held_q && !bvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rresp   = rresp_q;
  assign s_axi_rdata   = rdata_q;
  assign cls_rsp       = rsp_q;

  assign do_write = aw_held_q && w_held_q && !bvalid_q;
  assign ar_idx   = s_axi_araddr[IDX_LSB +: IDX_W];
  assign aw_sel   = reg_slot(aw_idx_q);
  assign ar_sel   = reg_slot(ar_idx);

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      aw_held_q <= 1'b0;
      aw_idx_q  <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_q <= 1'b1;
      aw_idx_q  <= s_axi_awaddr[IDX_LSB +: IDX_W];
    end else if (do_write) begin
      aw_held_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      w_held_q <= 1'b0;
      wdata_q  <= '0;
      wlane0_q <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_q <= 1'b1;
      wdata_q  <= s_axi_wdata;
      wlane0_q <= s_axi_wstrb[0];
    end else if (do_write) begin
      w_held_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end else if (do_write) begin
      bvalid_q <= 1'b1;
      bresp_q  <= is_mapped(aw_idx_q) ? RESP_OKAY : RESP_DECERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // only byte lane 0 carries writable register bits; bits 7 and 3 are simply not stored
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      for (int i = 0; i < MAP_REGS; i++) begin
        map_lo_q[i] <= MAP_RESET;
        map_hi_q[i] <= MAP_RESET;
      end
    end else if (do_write && wlane0_q && aw_sel.hit) begin
      map_lo_q[aw_sel.slot] <= wdata_q[LO_LSB +: PRIO_W];
      map_hi_q[aw_sel.slot] <= wdata_q[HI_LSB +: PRIO_W];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      remap_en_q <= REMAP_EN_RST;
    end else if (do_write && wlane0_q && (aw_idx_q == IDX_REMAP_EN)) begin
      remap_en_q <= wdata_q[REMAP_EN_BIT];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rvalid_q <= 1'b0;
      rresp_q  <= RESP_OKAY;
      rdata_q  <= '0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_q <= 1'b1;
      rresp_q  <= is_mapped(ar_idx) ? RESP_OKAY : RESP_DECERR;
      rdata_q  <= '0;
      if (ar_sel.hit) begin
        rdata_q[LO_LSB +: PRIO_W] <= map_lo_q[ar_sel.slot];
        rdata_q[HI_LSB +: PRIO_W] <= map_hi_q[ar_sel.slot];
      end else if (ar_idx == IDX_REMAP_EN) begin
        rdata_q[REMAP_EN_BIT] <= remap_en_q;
      end else if (ar_idx == IDX_STATUS) begin
        rdata_q[ST_PRIO_LSB +: PRIO_W] <= rsp_q.prio;
        rdata_q[ST_REMAP_BIT]          <= rsp_q.remapped;
        rdata_q[ST_DSCP_LSB +: DSCP_W] <= last_dscp_q;
      end
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // lookup reads the table directly, so a write retired before the request is seen at once
  assign req_pair    = cls_req.dscp[DSCP_W-1:1];
  assign req_sel     = pair_slot(req_pair);
  assign req_covered = req_sel.hit;
  assign req_slot    = req_sel.slot;
  assign table_prio  = cls_req.dscp[0] ? map_hi_q[req_slot] : map_lo_q[req_slot];

  // code points outside this table fall back to the class bits even with remap on
  always_comb begin
    rsp_d.valid = cls_req.valid;
    if (remap_en_q && req_covered) begin
      rsp_d.remapped = 1'b1;
      rsp_d.prio     = table_prio;
    end else begin
      rsp_d.remapped = 1'b0;
      rsp_d.prio     = cls_req.dscp[CLASS_LSB +: PRIO_W];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rsp_q <= '0;
    end else begin
      rsp_q.valid <= rsp_d.valid;
      if (cls_req.valid) begin
        rsp_q.remapped <= rsp_d.remapped;
        rsp_q.prio     <= rsp_d.prio;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      last_dscp_q <= '0;
    end else if (cls_req.valid) begin
      last_dscp_q <= cls_req.dscp;
    end
  end

endmodule

// [sim/drt_remap_checker.sv]
// port assertions for drt_remap_table
// bound into the design; one clock, synchronous reset
`timescale 1ns/10ps
module drt_remap_checker (
  input wire logic                   clk_sys,
  input wire logic                   reset,
  input wire logic                   s_axi_awready,
  input wire logic                   s_axi_wready,
  input wire logic                   s_axi_bvalid,
  input wire logic                   s_axi_bready,
  input wire logic                   s_axi_arready,
  input wire logic [31:0]            s_axi_rdata,
  input wire logic                   s_axi_rvalid,
  input wire drt_pkg::drt_dscp_req_s cls_req,
  input wire drt_pkg::drt_prio_rsp_s cls_rsp
);
  import drt_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  rsp_pulse_a: assert property (cls_req.valid |=> cls_rsp.valid)
    else $error("classifier answer missing");
  rsp_idle_a: assert property (!cls_req.valid |=> !cls_rsp.valid && $stable(cls_rsp.prio))
    else $error("classifier answer without request");
  direct_prio_a: assert property (cls_req.valid |=> cls_rsp.remapped ||
    cls_rsp.prio == $past(cls_req.dscp[5:3])) else $error("direct priority wrong");
  remap_range_a: assert property (cls_req.valid &&
    (cls_req.dscp < 6'h06 || cls_req.dscp > 6'h1D) |=> !cls_rsp.remapped)
    else $error("remap outside covered code points");
  rd_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:14] == 18'h0)
    else $error("read data upper bits set");
  b_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
  b_retire_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response not retired");
endmodule
bind drt_remap_table drt_remap_checker u_chk (
  .clk_sys(clk_sys), .reset(reset), .s_axi_awready(s_axi_awready),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .cls_req(cls_req), .cls_rsp(cls_rsp)
);

// [sim/testbench.sv]
// bench for drt_remap_table: axi4-lite tasks and classifier requests
// drives every port itself; aw and ar share one address, one access at a time
`timescale 1ns/10ps
module testbench;
  import drt_pkg::*;
  logic          clk_sys = 1'b0;
  logic          reset   = 1'b1;
  logic [11:0]   addr    = 12'h0;
  logic [31:0]   wdata   = 32'h0;
  logic [3:0]    strb    = 4'h0;
  logic          awvalid = 1'b0;
  logic          wvalid  = 1'b0;
  logic          bready  = 1'b0;
  logic          arvalid = 1'b0;
  logic          rready  = 1'b0;
  drt_dscp_req_s req     = '0;
  drt_prio_rsp_s rsp;
  logic          awready, wready, bvalid, arready, rvalid;
  logic [1:0]    bresp, rresp;
  logic [31:0]   rdata, rd;
  int            err_count = 0;
  int            num_checks = 0;
  drt_remap_table u_dut (
    .clk_sys(clk_sys), .reset(reset), .s_axi_awaddr(addr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(strb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(addr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .cls_req(req), .cls_rsp(rsp)
  );
  initial begin
    forever #2.5 clk_sys = ~clk_sys;
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] e);
    @(posedge clk_sys);
    addr    <= a;
    wdata   <= d;
    strb    <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    // aw and w may be taken on different edges
    do begin
      @(posedge clk_sys);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (awvalid && !awready || wvalid && !wready);
    do @(posedge clk_sys); while (!bvalid);
    bready <= 1'b0;
    chk("bresp", e, bresp);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [1:0] e);
    @(posedge clk_sys);
    addr    <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge clk_sys); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clk_sys); while (!rvalid);
    rready <= 1'b0;
    rd = rdata;
    chk("rresp", e, rresp);
  endtask
  task automatic cl(input logic [5:0] d, input logic [4:0] e);
    @(posedge clk_sys);
    req <= '{1'b1, d};
    @(posedge clk_sys);
    req.valid <= 1'b0;
    #1;
    chk("cls_rsp", e, rsp);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    #20000;
    err_count++;
    close_out();
  end
  initial begin
    logic [2:0] p;
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
    for (int i = 0; i < MAP_REGS; i++) begin
      rdc({IDX_MAP_FIRST + 10'(i), 2'b00}, RESP_OKAY);
      chk("map reset", 32'h0, rd);
    end
    rdc({IDX_REMAP_EN, 2'b00}, RESP_OKAY);
    chk("enable reset", 32'h0, rd);
    $display("test reset done");
    // all-ones in reserved bits must not stick
    for (int i = 0; i < MAP_REGS; i++) begin
      wr({IDX_MAP_FIRST + 10'(i), 2'b00}, {25'h1FFFFFF, ~3'(i), 1'b1, 3'(i)}, 4'hF, RESP_OKAY);
      rdc({IDX_MAP_FIRST + 10'(i), 2'b00}, RESP_OKAY);
      chk("map rw", {25'h0, ~3'(i), 1'b0, 3'(i)}, rd);
    end
    wr({IDX_MAP_FIRST, 2'b00}, 32'h0, 4'h0, RESP_OKAY);
    rdc({IDX_MAP_FIRST, 2'b00}, RESP_OKAY);
    chk("strobe off", 32'h70, rd);
    wr(12'h004, 32'h7, 4'hF, RESP_DECERR);
    rdc(12'h004, RESP_DECERR);
    chk("unmapped", 32'h0, rd);
    $display("test access done");
    cl(6'h07, 5'h10);
    cl(6'h3F, 5'h17);
    $display("test direct done");
    wr({IDX_REMAP_EN, 2'b00}, 32'h1, 4'hF, RESP_OKAY);
    for (int d = 6; d <= 29; d++) begin
      p = d[0] ? ~3'(d / 2 - 3) : 3'(d / 2 - 3);
      cl(6'(d), {2'b11, p});
    end
    cl(6'h05, 5'h10);
    cl(6'h3F, 5'h17);
    rdc({IDX_REMAP_EN, 2'b00}, RESP_OKAY);
    chk("enable rw", 32'h1, rd);
    rdc({IDX_STATUS, 2'b00}, RESP_OKAY);
    chk("status", 32'h3F07, rd);
    $display("test remap done");
    // second reset in mid-run must clear table and enable again
    @(posedge clk_sys);
    reset <= 1'b1;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    rdc({IDX_MAP_FIRST, 2'b00}, RESP_OKAY);
    chk("map rereset", 32'h0, rd);
    cl(6'h07, 5'h10);
    $display("test rereset done");
    close_out();
  end
endmodule
